// *** src/rcr_pkg.sv ***
package rcr_pkg;

  // Clock rate and documented timeouts.
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned OVERRIDE_SEC    = 4;
  localparam int unsigned ENTRY_TMO_SEC   = 4;
  localparam int unsigned ACK_TMO_SEC     = 4;
  localparam int unsigned OVERRIDE_CYC    = OVERRIDE_SEC * CLK_HZ;
  localparam int unsigned ENTRY_TMO_CYC   = ENTRY_TMO_SEC * CLK_HZ;
  localparam int unsigned ACK_TMO_CYC     = ACK_TMO_SEC * CLK_HZ;

  // Fields of the reset control byte, and the counter width.
  localparam int unsigned RSTCTL_PWRCYC_BIT = 3;
  localparam int unsigned RSTCTL_W          = 8;
  localparam int unsigned CNT_W             = 32;

  // Sleep state codes.
  localparam logic [2:0] SLP_S0 = 3'h0;
  localparam logic [2:0] SLP_S3 = 3'h3;
  localparam logic [2:0] SLP_S4 = 3'h4;
  localparam logic [2:0] SLP_S5 = 3'h5;

  // Reset outcomes, least to most severe.
  typedef enum logic [2:0] {
    RCR_NONE,
    RCR_HOST_WARM,
    RCR_HOST_COLD,
    RCR_STRAIGHT_S5,
    RCR_GLOBAL
  } rcr_kind_e;

  // Sequencer states.
  typedef enum logic [2:0] {
    RCR_IDLE,
    RCR_WARN,
    RCR_RESET,
    RCR_OFF_WAIT,
    RCR_DONE
  } rcr_state_e;

endpackage

// *** src/rcr_timer.sv ***
`timescale 1ns/1ps

// Up counter from zero that pulses once when the count reaches the limit.
module rcr_timer (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        run_in,
  input  wire logic [31:0] limit_in,
  output logic             expire_out
);

  logic [31:0] count_r;
  logic        fired_r;

  // =======================================================
  // Counting
  // Dropping run clears the count, so each start measures afresh.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_r <= 32'h0;
      fired_r <= 1'b0;
    end else if (!run_in) begin
      count_r <= 32'h0;
      fired_r <= 1'b0;
    end else if (!fired_r) begin
      count_r <= count_r + 32'h1;
      fired_r <= (count_r + 32'h1) >= limit_in;
    end
  end

  // The pulse appears on the cycle the limit is first reached.
  assign expire_out = run_in && !fired_r && ((count_r + 32'h1) >= limit_in);

endmodule

// *** src/rcr_sync.sv ***
`timescale 1ns/1ps

// Two flip-flop synchroniser for a bundle of pin levels.
module rcr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // =======================================================
  // Double register
  // Only the second stage is visible outside.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** src/rcr_resolver.sv ***
`timescale 1ns/1ps

module rcr_resolver #(
  parameter int unsigned OVERRIDE_CYC  = rcr_pkg::OVERRIDE_CYC,
  parameter int unsigned ENTRY_TMO_CYC = rcr_pkg::ENTRY_TMO_CYC,
  parameter int unsigned ACK_TMO_CYC   = rcr_pkg::ACK_TMO_CYC
) (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       power_button_n_in,
  input  wire logic       platform_power_good_in,
  input  wire logic       wake_event_in,
  input  wire logic [7:0] reset_control_reg_in,
  input  wire logic       global_reset_bit_in,
  input  wire logic       global_reset_promotion_enable_in,
  input  wire logic [2:0] sleep_state_in,
  input  wire logic       sw_entered_sleep_in,
  input  wire logic       shutdown_cycle_in,
  input  wire logic       me_host_warm_in,
  input  wire logic       me_host_cold_in,
  input  wire logic       me_override_in,
  input  wire logic       me_global_in,
  input  wire logic       me_host_pwrdown_in,
  input  wire logic       me_watchdog_in,
  input  wire logic       me_uncorr_err_in,
  input  wire logic       pm_watchdog_in,
  input  wire logic       warn_ack_in,
  input  wire logic       reset_seq_done_in,
  output logic            platform_reset_out,
  output logic            reset_warn_out,
  output logic            sleep_wells_off_out,
  output logic            global_reset_out,
  output logic            busy_out,
  output logic [2:0]      outcome_out
);

  // =======================================================
  // Pin synchronisation
  // Pins from outside pass two flops; request strobes are on-clock logic.
  logic [1:0] pins_sync;
  logic       button_held;
  logic       pwr_good;
  logic       pwr_good_seen_r;

  rcr_sync #(.W(2)) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({~power_button_n_in, platform_power_good_in}),
    .sync_out   (pins_sync)
  );

  assign button_held = pins_sync[1];
  assign pwr_good    = pins_sync[0];

  // =======================================================
  // Timers
  rcr_pkg::rcr_state_e state_r;
  rcr_pkg::rcr_state_e state_nxt;
  rcr_pkg::rcr_kind_e  kind_r;
  rcr_pkg::rcr_kind_e  req_kind;
  logic                skip_warn_r;
  logic                override_tmo;
  logic                entry_tmo;
  logic                ack_tmo;
  logic                stuck_low;

  // The override timer fires once per press, so a held button never retriggers.
  rcr_timer u_override (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (button_held),
    .limit_in   (OVERRIDE_CYC),
    .expire_out (override_tmo)
  );

  // Measures platform reset entry from the start of the reset phase.
  rcr_timer u_entry (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (state_r == rcr_pkg::RCR_RESET),
    .limit_in   (ENTRY_TMO_CYC),
    .expire_out (entry_tmo)
  );

  rcr_timer u_ack (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (state_r == rcr_pkg::RCR_WARN),
    .limit_in   (ACK_TMO_CYC),
    .expire_out (ack_tmo)
  );

  // Power good stuck low: seen high once, now missing in S0 while the sequencer is idle.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwr_good_seen_r <= 1'b0;
    end else if (pwr_good) begin
      pwr_good_seen_r <= 1'b1;
    end else if (state_r == rcr_pkg::RCR_RESET) begin
      pwr_good_seen_r <= 1'b0;
    end
  end
  assign stuck_low = pwr_good_seen_r && !pwr_good && (sleep_state_in == rcr_pkg::SLP_S0)
                     && (state_r == rcr_pkg::RCR_IDLE);

  // =======================================================
  // Trigger resolution
  // Severity order is encoded in the enum, so the highest request wins.
  function automatic rcr_pkg::rcr_kind_e rcr_max(input rcr_pkg::rcr_kind_e a,
                                                 input rcr_pkg::rcr_kind_e b);
    rcr_max = (a > b) ? a : b;
  endfunction

  logic in_s45;
  logic in_s0;
  logic wd_any;
  logic cold_req;
  logic warm_req;

  assign in_s45   = (sleep_state_in == rcr_pkg::SLP_S4) || (sleep_state_in == rcr_pkg::SLP_S5);
  assign in_s0    = (sleep_state_in == rcr_pkg::SLP_S0);
  assign wd_any   = me_watchdog_in || pm_watchdog_in || me_uncorr_err_in;
  assign cold_req = (shutdown_cycle_in && !global_reset_bit_in
                     && reset_control_reg_in[rcr_pkg::RSTCTL_PWRCYC_BIT])
                    || me_host_cold_in || me_host_pwrdown_in;
  assign warm_req = (shutdown_cycle_in && !global_reset_bit_in
                     && !reset_control_reg_in[rcr_pkg::RSTCTL_PWRCYC_BIT])
                    || me_host_warm_in;

  always_comb begin
    req_kind = rcr_pkg::RCR_NONE;
    if (warm_req && !in_s45) begin
      req_kind = rcr_pkg::RCR_HOST_WARM;
    end
    if (cold_req) begin
      req_kind = rcr_max(req_kind, rcr_pkg::RCR_HOST_COLD);
    end
    if (override_tmo || me_override_in || (wd_any && !global_reset_promotion_enable_in)
        || (wd_any && !in_s0)) begin
      req_kind = rcr_max(req_kind, rcr_pkg::RCR_STRAIGHT_S5);
    end
    if ((shutdown_cycle_in && global_reset_bit_in) || me_global_in || stuck_low
        || (wd_any && global_reset_promotion_enable_in && in_s0)) begin
      req_kind = rcr_pkg::RCR_GLOBAL;
    end
  end

  // =======================================================
  // Sequencer
  // A global outcome may pre-empt any running sequence not already global; lesser ones are taken only in idle.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rcr_pkg::RCR_IDLE: begin
        if (req_kind == rcr_pkg::RCR_GLOBAL || req_kind == rcr_pkg::RCR_STRAIGHT_S5) begin
          state_nxt = rcr_pkg::RCR_RESET;
        end else if (req_kind != rcr_pkg::RCR_NONE) begin
          state_nxt = (cold_req && in_s45 && sw_entered_sleep_in) ?
                      rcr_pkg::RCR_RESET : rcr_pkg::RCR_WARN;
        end
      end
      rcr_pkg::RCR_WARN: begin
        if (warn_ack_in || ack_tmo) begin
          state_nxt = rcr_pkg::RCR_RESET;
        end
      end
      rcr_pkg::RCR_RESET: begin
        if (entry_tmo) begin
          state_nxt = rcr_pkg::RCR_RESET;
        end else if (reset_seq_done_in) begin
          state_nxt = (kind_r == rcr_pkg::RCR_HOST_WARM || kind_r == rcr_pkg::RCR_GLOBAL) ?
                      rcr_pkg::RCR_DONE : rcr_pkg::RCR_OFF_WAIT;
        end
      end
      rcr_pkg::RCR_OFF_WAIT: begin
        if (wake_event_in || (kind_r == rcr_pkg::RCR_HOST_COLD && !skip_warn_r)) begin
          state_nxt = rcr_pkg::RCR_DONE;
        end
      end
      rcr_pkg::RCR_DONE: begin
        state_nxt = rcr_pkg::RCR_IDLE;
      end
      default: begin
        state_nxt = rcr_pkg::RCR_IDLE;
      end
    endcase
    if (req_kind == rcr_pkg::RCR_GLOBAL && kind_r != rcr_pkg::RCR_GLOBAL) begin
      state_nxt = rcr_pkg::RCR_RESET;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= rcr_pkg::RCR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outcome capture; timeouts escalate whatever was running to global.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      kind_r      <= rcr_pkg::RCR_NONE;
      skip_warn_r <= 1'b0;
    end else if (ack_tmo || entry_tmo) begin
      kind_r <= rcr_pkg::RCR_GLOBAL;
    end else if (req_kind == rcr_pkg::RCR_GLOBAL) begin
      kind_r <= rcr_pkg::RCR_GLOBAL;
    end else if (state_r == rcr_pkg::RCR_IDLE && req_kind != rcr_pkg::RCR_NONE) begin
      kind_r      <= req_kind;
      // Power-down request is remembered so the off phase waits for wake.
      skip_warn_r <= me_host_pwrdown_in;
    end else if (state_r == rcr_pkg::RCR_DONE) begin
      kind_r      <= rcr_pkg::RCR_NONE;
      skip_warn_r <= 1'b0;
    end
  end

  // =======================================================
  // Outputs
  // Wells stay off in the off phase (cold, straight to S5) and in reset for straight to S5; global leaves them on.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      platform_reset_out  <= 1'b0;
      reset_warn_out      <= 1'b0;
      sleep_wells_off_out <= 1'b0;
      global_reset_out    <= 1'b0;
      outcome_out         <= 3'h0;
    end else begin
      platform_reset_out  <= (state_nxt == rcr_pkg::RCR_RESET)
                             || (state_nxt == rcr_pkg::RCR_OFF_WAIT);
      reset_warn_out      <= (state_nxt == rcr_pkg::RCR_WARN);
      sleep_wells_off_out <= (state_nxt == rcr_pkg::RCR_OFF_WAIT)
                             || ((state_nxt == rcr_pkg::RCR_RESET)
                                 && (kind_r == rcr_pkg::RCR_STRAIGHT_S5
                                     || req_kind == rcr_pkg::RCR_STRAIGHT_S5));
      global_reset_out    <= (state_nxt == rcr_pkg::RCR_RESET)
                             && (kind_r == rcr_pkg::RCR_GLOBAL
                                 || req_kind == rcr_pkg::RCR_GLOBAL
                                 || ack_tmo || entry_tmo);
      outcome_out         <= 3'(kind_r);
    end
  end

  assign busy_out = (state_r != rcr_pkg::RCR_IDLE);

  // =======================================================
  // Assertions
  property p_global_no_warn;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == rcr_pkg::RCR_IDLE && req_kind == rcr_pkg::RCR_GLOBAL)
      |=> (state_r == rcr_pkg::RCR_RESET) && !reset_warn_out;
  endproperty
  a_global_no_warn: assert property (p_global_no_warn)
    else $error("Global reset went through the warning phase.");

  property p_warm_dropped;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == rcr_pkg::RCR_IDLE && warm_req && in_s45 && !cold_req
       && !wd_any && !me_override_in && !me_global_in && !shutdown_cycle_in
       && !override_tmo && !stuck_low) |=> (state_r == rcr_pkg::RCR_IDLE);
  endproperty
  a_warm_dropped: assert property (p_warm_dropped)
    else $error("Warm reset request accepted in S4 or S5.");

  property p_ack_timeout;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == rcr_pkg::RCR_WARN && ack_tmo) |=> (kind_r == rcr_pkg::RCR_GLOBAL);
  endproperty
  a_ack_timeout: assert property (p_ack_timeout)
    else $error("Missing acknowledge did not escalate to global.");

  property p_promote;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (wd_any && global_reset_promotion_enable_in && in_s0)
      |=> (kind_r == rcr_pkg::RCR_GLOBAL);
  endproperty
  a_promote: assert property (p_promote)
    else $error("Watchdog in S0 with promotion was not global.");

  property p_wd_s5;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == rcr_pkg::RCR_IDLE && wd_any && !global_reset_promotion_enable_in)
      |=> (kind_r >= rcr_pkg::RCR_STRAIGHT_S5);
  endproperty
  a_wd_s5: assert property (p_wd_s5)
    else $error("Watchdog did not go straight to S5.");

  property p_me_global;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      me_global_in |=> (kind_r == rcr_pkg::RCR_GLOBAL);
  endproperty
  a_me_global: assert property (p_me_global)
    else $error("Engine global request not resolved as global.");

  property p_s5_wells;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == rcr_pkg::RCR_OFF_WAIT && kind_r == rcr_pkg::RCR_STRAIGHT_S5)
      |-> sleep_wells_off_out && platform_reset_out;
  endproperty
  a_s5_wells: assert property (p_s5_wells)
    else $error("Wells on during straight to S5.");

  property p_shutdown_cold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == rcr_pkg::RCR_IDLE && shutdown_cycle_in && !global_reset_bit_in
       && reset_control_reg_in[rcr_pkg::RSTCTL_PWRCYC_BIT])
      |=> (kind_r >= rcr_pkg::RCR_HOST_COLD);
  endproperty
  a_shutdown_cold: assert property (p_shutdown_cold)
    else $error("Shutdown cycle with bit 3 set was not a cold reset.");

  c_global: cover property (@(posedge sys_clk_in) global_reset_out);
  c_warn_ack: cover property (@(posedge sys_clk_in) reset_warn_out ##1 warn_ack_in);
  c_off_wait: cover property (@(posedge sys_clk_in) state_r == rcr_pkg::RCR_OFF_WAIT);

endmodule

// *** verification/rcr_partner.sv ***
`timescale 1ns/1ps

// ============================================================
// Far side: platform reset logic and the engine's acknowledge.
module rcr_partner (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       reset_warn_in,
  input  wire logic       platform_reset_in,
  input  wire logic       ack_en_in,
  input  wire logic       done_en_in,
  input  wire logic [3:0] dly_in,
  output logic            warn_ack_out,
  output logic            seq_done_out
);
  logic [3:0] ack_cnt_r;
  logic [3:0] done_cnt_r;

  // Acknowledge follows the warning after a set delay, or never when withheld.
  always_ff @(negedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_cnt_r    <= 4'h0;
      warn_ack_out <= 1'b0;
    end else if (reset_warn_in && ack_en_in && ack_cnt_r == dly_in) begin
      ack_cnt_r    <= 4'h0;
      warn_ack_out <= 1'b1;
    end else begin
      ack_cnt_r    <= reset_warn_in ? ack_cnt_r + 4'h1 : 4'h0;
      warn_ack_out <= 1'b0;
    end
  end

  // Reset sequence completes some cycles into the reset; a stuck platform never does.
  always_ff @(negedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_cnt_r   <= 4'h0;
      seq_done_out <= 1'b0;
    end else if (platform_reset_in && done_en_in && done_cnt_r == dly_in) begin
      done_cnt_r   <= 4'h0;
      seq_done_out <= 1'b1;
    end else begin
      done_cnt_r   <= platform_reset_in ? done_cnt_r + 4'h1 : 4'h0;
      seq_done_out <= 1'b0;
    end
  end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps

module tb;
  localparam int unsigned TMO = 20;
  localparam int T_SHUT = 0, T_WARM = 1, T_COLD = 2, T_OVR = 3, T_GLOB = 4;
  localparam int T_PDN = 5, T_MEWD = 6, T_UNC = 7, T_PMWD = 8;
  localparam logic [2:0] K_WARM = rcr_pkg::RCR_HOST_WARM;
  localparam logic [2:0] K_COLD = rcr_pkg::RCR_HOST_COLD;
  localparam logic [2:0] K_S5   = rcr_pkg::RCR_STRAIGHT_S5;
  localparam logic [2:0] K_GLOB = rcr_pkg::RCR_GLOBAL;

  logic       clk, rst_n, btn_n, pg, wake, gbit, promo, sw_sleep, ack_en, done_en;
  logic [7:0] rctl;
  logic [2:0] slp, outcome;
  logic [8:0] trig;
  logic [3:0] dly;
  logic       warn_ack, seq_done, plt_rst, warn, wells_off, glob, busy, seen;
  int         failures, checks;

  // ============================================================
  // Design and far-side model.
  rcr_resolver #(.OVERRIDE_CYC(TMO), .ENTRY_TMO_CYC(TMO), .ACK_TMO_CYC(TMO)) dut (
    .sys_clk_in(clk), .reset_n_in(rst_n), .power_button_n_in(btn_n),
    .platform_power_good_in(pg), .wake_event_in(wake), .reset_control_reg_in(rctl),
    .global_reset_bit_in(gbit), .global_reset_promotion_enable_in(promo),
    .sleep_state_in(slp), .sw_entered_sleep_in(sw_sleep), .shutdown_cycle_in(trig[T_SHUT]),
    .me_host_warm_in(trig[T_WARM]), .me_host_cold_in(trig[T_COLD]),
    .me_override_in(trig[T_OVR]), .me_global_in(trig[T_GLOB]),
    .me_host_pwrdown_in(trig[T_PDN]), .me_watchdog_in(trig[T_MEWD]),
    .me_uncorr_err_in(trig[T_UNC]), .pm_watchdog_in(trig[T_PMWD]),
    .warn_ack_in(warn_ack), .reset_seq_done_in(seq_done), .platform_reset_out(plt_rst),
    .reset_warn_out(warn), .sleep_wells_off_out(wells_off), .global_reset_out(glob),
    .busy_out(busy), .outcome_out(outcome));

  rcr_partner partner (
    .sys_clk_in(clk), .reset_n_in(rst_n), .reset_warn_in(warn),
    .platform_reset_in(plt_rst), .ack_en_in(ack_en), .done_en_in(done_en),
    .dly_in(dly), .warn_ack_out(warn_ack), .seq_done_out(seq_done));

  // The 25 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ============================================================
  // Shared helpers.
  task automatic check(input logic cond, input string msg);
    checks++;
    if (cond !== 1'b1) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // Pulses one or more triggers for exactly one rising edge.
  task automatic fire(input logic [8:0] mask);
    @(negedge clk);
    trig = mask;
    @(negedge clk);
    trig = 9'h000;
  endtask

  // Waits for the platform reset, noting whether a warning came first.
  task automatic wait_reset;
    int n;
    n = 0;
    seen = warn;
    while (plt_rst !== 1'b1 && n < 100) begin
      @(negedge clk);
      seen = seen | warn;
      n++;
    end
    check(n < 100, "platform reset never asserted");
  endtask

  // Waits for idle; wake is offered only when need_wake is set.
  task automatic finish_seq(input logic need_wake);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(negedge clk);
      wake = need_wake;
      n++;
    end
    wake = 1'b0;
    check(n < 200, "sequence did not finish");
    check(plt_rst === 1'b0, "platform reset not released");
  endtask

  task automatic expect_kind(input logic [2:0] kind, input logic warned, input logic need_wake);
    wait_reset();
    check(seen === warned, "warning handshake wrong");
    @(negedge clk);
    check(outcome === kind, "outcome kind wrong");
    check(glob === (kind == K_GLOB), "global phase wrong");
    if (kind == K_S5) check(wells_off === 1'b1, "sleep wells still on");
    finish_seq(need_wake);
  endtask

  // ============================================================
  // Scenarios.
  task automatic t_engine;
    fire(9'h1 << T_WARM);
    expect_kind(K_WARM, 1'b1, 1'b0);
    fire(9'h1 << T_COLD);
    expect_kind(K_COLD, 1'b1, 1'b0);
    fire(9'h1 << T_GLOB);
    expect_kind(K_GLOB, 1'b0, 1'b0);
    fire(9'h1 << T_OVR);
    expect_kind(K_S5, 1'b0, 1'b1);
    $display("test engine requests done");
  endtask

  task automatic t_shutdown;
    for (int i = 0; i < 3; i++) begin
      gbit = (i == 0);
      rctl = (i == 1) ? 8'h0E : 8'h06;
      fire(9'h1 << T_SHUT);
      expect_kind(i == 0 ? K_GLOB : (i == 1 ? K_COLD : K_WARM), i != 0, 1'b0);
    end
    gbit = 1'b0;
    $display("test shutdown cycles done");
  endtask

  task automatic t_watchdogs;
    for (int i = 0; i < 3; i++) begin
      promo = (i != 1);
      slp = (i == 2) ? rcr_pkg::SLP_S3 : rcr_pkg::SLP_S0;
      fire(9'h1 << (i == 0 ? T_PMWD : (i == 1 ? T_MEWD : T_UNC)));
      expect_kind(i == 0 ? K_GLOB : K_S5, 1'b0, 1'b1);
    end
    promo = 1'b0;
    slp = rcr_pkg::SLP_S0;
    $display("test watchdogs done");
  endtask

  task automatic t_ack_timeout;
    ack_en = 1'b0;
    fire(9'h1 << T_WARM);
    expect_kind(K_GLOB, 1'b1, 1'b0);
    ack_en = 1'b1;
    $display("test acknowledge timeout done");
  endtask

  task automatic t_sleep_states;
    slp = rcr_pkg::SLP_S5;
    sw_sleep = 1'b1;
    fire(9'h1 << T_WARM);
    repeat (10) @(negedge clk);
    check(busy === 1'b0 && warn === 1'b0 && plt_rst === 1'b0, "warm reset not dropped");
    fire(9'h1 << T_COLD);
    expect_kind(K_COLD, 1'b0, 1'b0);
    slp = rcr_pkg::SLP_S4;
    sw_sleep = 1'b0;
    fire(9'h1 << T_COLD);
    expect_kind(K_COLD, 1'b1, 1'b0);
    slp = rcr_pkg::SLP_S0;
    sw_sleep = 1'b0;
    $display("test sleep states done");
  endtask

  task automatic t_pwrdown;
    fire(9'h1 << T_PDN);
    wait_reset();
    check(seen === 1'b1, "power-down reset not warned");
    repeat (30) @(negedge clk);
    check(plt_rst === 1'b1 && busy === 1'b1, "reset completed without wake");
    finish_seq(1'b1);
    $display("test power-down reset done");
  endtask

  task automatic t_button;
    @(negedge clk);
    btn_n = 1'b0;
    wait_reset();
    @(negedge clk);
    check(outcome === K_S5 && wells_off === 1'b1, "override did not reach S5");
    btn_n = 1'b1;
    repeat (TMO) @(negedge clk);
    check(wells_off === 1'b1 && busy === 1'b1, "host left S5 without wake");
    finish_seq(1'b1);
    $display("test button override done");
  endtask

  task automatic t_entry_timeout;
    done_en = 1'b0;
    fire(9'h1 << T_OVR);
    wait_reset();
    repeat (TMO + 10) @(negedge clk);
    check(outcome === K_GLOB && glob === 1'b1, "entry timeout not global");
    done_en = 1'b1;
    finish_seq(1'b1);
    $display("test entry timeout done");
  endtask

  task automatic t_power_good;
    int n;
    n = 0;
    @(negedge clk);
    pg = 1'b0;
    while (glob !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(glob === 1'b1 && warn === 1'b0, "power-good loss not global");
    pg = 1'b1;
    finish_seq(1'b0);
    $display("test power-good loss done");
  endtask

  task automatic t_priority;
    fire((9'h1 << T_WARM) | (9'h1 << T_PMWD));
    expect_kind(K_S5, 1'b0, 1'b1);
    fire(9'h1 << T_WARM);
    check(warn === 1'b1, "warning not raised");
    fire(9'h1 << T_GLOB);
    expect_kind(K_GLOB, 1'b0, 1'b0);
    $display("test priority done");
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ============================================================
  // Main sequence.
  initial begin
    failures = 0;
    checks = 0;
    {rst_n, wake, gbit, promo, sw_sleep} = 5'h00;
    {btn_n, pg, ack_en, done_en} = 4'hF;
    rctl = 8'h00;
    slp = rcr_pkg::SLP_S0;
    trig = 9'h000;
    dly = 4'h3;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_engine();
    t_shutdown();
    t_watchdogs();
    t_ack_timeout();
    t_sleep_states();
    t_pwrdown();
    t_button();
    t_entry_timeout();
    t_power_good();
    t_priority();
    tally_and_finish();
  end
endmodule
